// File: inc/rrsx_regs.vh
`ifndef RRSX_REGS_VH
`define RRSX_REGS_VH
// ==========================================
// operation codes presented on I_OP
`define RRSX_OP_NONE 4'h0
`define RRSX_OP_INTERRUPT_RETURN 4'h1
`define RRSX_OP_LITERAL_RETURN 4'h2
`define RRSX_OP_RETURN 4'h3
`define RRSX_OP_ROTATE_LEFT 4'h4
`define RRSX_OP_ROTATE_RIGHT 4'h5
`define RRSX_OP_SLEEP 4'h6
`define RRSX_OP_HALT 4'h7
`define RRSX_OP_LITERAL_SUBTRACT 4'h8
`define RRSX_OP_FILE_SUBTRACT 4'h9
`define RRSX_OP_FILE_SUBTRACT_BORROW 4'hA
`define RRSX_OP_LITERAL_XOR 4'hB
`define RRSX_OP_FILE_XOR 4'hC
`define RRSX_OP_CALL 4'hD
// ==========================================
// reset values and timing
`define RRSX_W_RESET 8'h00
`define RRSX_PC_RESET 12'h000
`define RRSX_RETURN_CYCLES 2
`define RRSX_ONE_CYCLE 1
`endif

// File: hw/rrsx_exec.v
`timescale 1ns/1ns
`default_nettype none
`include "rrsx_regs.vh"
module rrsx_exec #(
  parameter STACK_DEPTH = 8,
  parameter PC_WIDTH = 12
) (
  input wire I_CLOCK,
  input wire I_RST,
  input wire [3:0] I_OP,
  input wire I_OP_VALID,
  input wire [7:0] I_LITERAL,
  input wire [7:0] I_FILE_DATA,
  input wire I_DEST,
  input wire [PC_WIDTH-1:0] I_CALL_ADDR,
  input wire I_INT_WAKE,
  input wire I_EXT_WAKE,
  output reg O_BUSY,
  output reg [7:0] O_W,
  output reg O_CARRY,
  output reg O_DIGIT_CARRY,
  output reg O_ZERO,
  output reg O_GLOBAL_INTERRUPT_ENABLE,
  output reg O_POWER_DOWN_FLAG,
  output reg [PC_WIDTH-1:0] O_PC,
  output reg O_PC_LOAD,
  output reg [7:0] O_FILE_WDATA,
  output reg O_FILE_WE,
  output reg O_CORE_CLOCK_STOP,
  output reg O_OSC_STOP,
  output reg O_STACK_OVERFLOW
);
  // ==========================================
  // state
  localparam ST_RUN = 2'b00;
  localparam ST_RET = 2'b01;
  localparam ST_HALT = 2'b10;
  localparam ST_SLEEP = 2'b11;
  localparam SP_W = 4;

  reg [1:0] state_ff;
  reg [PC_WIDTH-1:0] stack_mem [0:STACK_DEPTH-1];
  reg [SP_W-1:0] sp_ff;
  reg [PC_WIDTH-1:0] ret_pc_ff;
  reg ret_gie_ff;

  // ==========================================
  // arithmetic
  wire [7:0] wv = O_W;
  wire [7:0] sub_a = (I_OP == `RRSX_OP_LITERAL_SUBTRACT) ? I_LITERAL : I_FILE_DATA;
  wire borrow_in = (I_OP == `RRSX_OP_FILE_SUBTRACT_BORROW) ? ~O_CARRY : 1'b0;
  // add a + ~w + (1-borrow); carry out set means no borrow
  wire [8:0] sub_full = {1'b0, sub_a} + {1'b0, ~wv} + {8'h00, ~borrow_in};
  wire [4:0] sub_low = {1'b0, sub_a[3:0]} + {1'b0, ~wv[3:0]} + {4'h0, ~borrow_in};
  wire [7:0] rol_v = {I_FILE_DATA[6:0], O_CARRY};
  wire [7:0] ror_v = {O_CARRY, I_FILE_DATA[7:1]};
  wire [7:0] xor_v = wv ^ ((I_OP == `RRSX_OP_LITERAL_XOR) ? I_LITERAL : I_FILE_DATA);
  wire [SP_W-1:0] sp_top = sp_ff - 4'h1;

  // ==========================================
  // single process updating datapath and state
  always @(posedge I_CLOCK) begin
    if (I_RST) begin
      state_ff <= ST_RUN;
      sp_ff <= 4'h0;
      ret_pc_ff <= `RRSX_PC_RESET;
      ret_gie_ff <= 1'b0;
      O_BUSY <= 1'b0;
      O_W <= `RRSX_W_RESET;
      O_CARRY <= 1'b0;
      O_DIGIT_CARRY <= 1'b0;
      O_ZERO <= 1'b0;
      O_GLOBAL_INTERRUPT_ENABLE <= 1'b0;
      O_POWER_DOWN_FLAG <= 1'b0;
      O_PC <= `RRSX_PC_RESET;
      O_PC_LOAD <= 1'b0;
      O_FILE_WDATA <= 8'h00;
      O_FILE_WE <= 1'b0;
      O_CORE_CLOCK_STOP <= 1'b0;
      O_OSC_STOP <= 1'b0;
      O_STACK_OVERFLOW <= 1'b0;
    end else begin
      O_PC_LOAD <= 1'b0;
      O_FILE_WE <= 1'b0;
      case (state_ff)
        ST_RUN: begin
          if (I_OP_VALID) begin
            case (I_OP)
              `RRSX_OP_INTERRUPT_RETURN, `RRSX_OP_LITERAL_RETURN, `RRSX_OP_RETURN: begin
                // first cycle: pop top entry, second cycle loads pc
                ret_pc_ff <= stack_mem[sp_top[2:0]];
                sp_ff <= sp_top;
                ret_gie_ff <= (I_OP == `RRSX_OP_INTERRUPT_RETURN);
                if (I_OP == `RRSX_OP_LITERAL_RETURN)
                  O_W <= I_LITERAL;
                O_BUSY <= 1'b1;
                state_ff <= ST_RET;
              end
              `RRSX_OP_CALL: begin
                // push for subroutine entry; when full the pointer holds, overflow is flagged and entry 0 is overwritten
                stack_mem[sp_ff[2:0]] <= I_CALL_ADDR;
                if (sp_ff == STACK_DEPTH)
                  O_STACK_OVERFLOW <= 1'b1;
                else
                  sp_ff <= sp_ff + 4'h1;
              end
              `RRSX_OP_ROTATE_LEFT: begin
                O_CARRY <= I_FILE_DATA[7];
                O_ZERO <= (rol_v == 8'h00);
                if (I_DEST) begin
                  O_FILE_WDATA <= rol_v;
                  O_FILE_WE <= 1'b1;
                end else
                  O_W <= rol_v;
              end
              `RRSX_OP_ROTATE_RIGHT: begin
                O_CARRY <= I_FILE_DATA[0];
                if (I_DEST) begin
                  O_FILE_WDATA <= ror_v;
                  O_FILE_WE <= 1'b1;
                end else
                  O_W <= ror_v;
              end
              `RRSX_OP_SLEEP: begin
                O_OSC_STOP <= 1'b1;
                O_CORE_CLOCK_STOP <= 1'b1;
                O_POWER_DOWN_FLAG <= 1'b1;
                O_BUSY <= 1'b1;
                state_ff <= ST_SLEEP;
              end
              `RRSX_OP_HALT: begin
                O_CORE_CLOCK_STOP <= 1'b1;
                O_BUSY <= 1'b1;
                state_ff <= ST_HALT;
              end
              `RRSX_OP_LITERAL_SUBTRACT: begin
                O_W <= sub_full[7:0];
                O_CARRY <= sub_full[8];
                O_DIGIT_CARRY <= sub_low[4];
                O_ZERO <= (sub_full[7:0] == 8'h00);
              end
              `RRSX_OP_FILE_SUBTRACT, `RRSX_OP_FILE_SUBTRACT_BORROW: begin
                O_CARRY <= sub_full[8];
                O_DIGIT_CARRY <= sub_low[4];
                O_ZERO <= (sub_full[7:0] == 8'h00);
                if (I_DEST) begin
                  O_FILE_WDATA <= sub_full[7:0];
                  O_FILE_WE <= 1'b1;
                end else
                  O_W <= sub_full[7:0];
              end
              `RRSX_OP_LITERAL_XOR: begin
                O_W <= xor_v;
                O_ZERO <= (xor_v == 8'h00);
              end
              `RRSX_OP_FILE_XOR: begin
                O_ZERO <= (xor_v == 8'h00);
                if (I_DEST) begin
                  O_FILE_WDATA <= xor_v;
                  O_FILE_WE <= 1'b1;
                end else
                  O_W <= xor_v;
              end
              default: begin
              end
            endcase
          end
        end
        ST_RET: begin
          // second cycle of every return
          O_PC <= ret_pc_ff;
          O_PC_LOAD <= 1'b1;
          if (ret_gie_ff)
            O_GLOBAL_INTERRUPT_ENABLE <= 1'b1;
          O_BUSY <= 1'b0;
          state_ff <= ST_RUN;
        end
        ST_HALT: begin
          // internal or external source resumes the core
          if (I_INT_WAKE || I_EXT_WAKE) begin
            O_CORE_CLOCK_STOP <= 1'b0;
            O_BUSY <= 1'b0;
            state_ff <= ST_RUN;
          end
        end
        ST_SLEEP: begin
          // only an external source restarts the oscillator
          if (I_EXT_WAKE) begin
            O_OSC_STOP <= 1'b0;
            O_CORE_CLOCK_STOP <= 1'b0;
            O_BUSY <= 1'b0;
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end
endmodule // rrsx_exec
`default_nettype wire

// File: testbench/rrsx_exec_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "rrsx_regs.vh"
// ==========================================
// port checker for the execute block
module rrsx_exec_chk (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [3:0] I_OP,
  input wire logic I_OP_VALID,
  input wire logic [7:0] I_LITERAL,
  input wire logic I_DEST,
  input wire logic O_BUSY,
  input wire logic [7:0] O_W,
  input wire logic O_CARRY,
  input wire logic O_ZERO,
  input wire logic O_GLOBAL_INTERRUPT_ENABLE,
  input wire logic O_PC_LOAD,
  input wire logic O_FILE_WE,
  input wire logic O_OSC_STOP
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // an instruction is taken only while idle
  wire take = I_OP_VALID && !O_BUSY;
  a_return_two_cycle: assert property (take && I_OP == `RRSX_OP_RETURN |=> O_BUSY ##1 !O_BUSY && O_PC_LOAD)
    else $error("plain return timing wrong");
  a_irq_return_enable: assert property (take && I_OP == `RRSX_OP_INTERRUPT_RETURN |=> ##1 O_GLOBAL_INTERRUPT_ENABLE)
    else $error("interrupt enable not set");
  a_lit_return_w: assert property (take && I_OP == `RRSX_OP_LITERAL_RETURN |=> O_W == $past(I_LITERAL))
    else $error("literal return value wrong");
  a_lit_xor_w: assert property (take && I_OP == `RRSX_OP_LITERAL_XOR |=>
    O_W == ($past(I_LITERAL) ^ $past(O_W)) && O_ZERO == (O_W == 8'h00)) else $error("literal xor wrong");
  a_lit_sub_carry: assert property (take && I_OP == `RRSX_OP_LITERAL_SUBTRACT |=>
    O_W == $past(I_LITERAL) - $past(O_W) && O_CARRY == ($past(I_LITERAL) >= $past(O_W))) else $error("sub wrong");
  a_rotr_zero_kept: assert property (take && I_OP == `RRSX_OP_ROTATE_RIGHT |=> $stable(O_ZERO))
    else $error("rotate right touched zero");
  a_file_dest_we: assert property (take && I_OP inside {`RRSX_OP_FILE_SUBTRACT, `RRSX_OP_FILE_XOR}
    |=> O_FILE_WE == $past(I_DEST)) else $error("destination select wrong");
  a_sleep_osc_stop: assert property (take && I_OP == `RRSX_OP_SLEEP |=> O_OSC_STOP && O_BUSY)
    else $error("sleep did not stop oscillator");
endmodule // rrsx_exec_chk
bind rrsx_exec rrsx_exec_chk chk (.*);
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "rrsx_regs.vh"
// ==========================================
// self-checking bench
module testbench;
  logic I_CLOCK = 0, I_RST = 1, I_OP_VALID = 0, I_DEST = 0, I_INT_WAKE = 0, I_EXT_WAKE = 0;
  logic [3:0] I_OP = 4'h0;
  logic [7:0] I_LITERAL = 8'h00, I_FILE_DATA = 8'h00, O_W, O_FILE_WDATA;
  logic [11:0] I_CALL_ADDR = 12'h000, O_PC;
  logic O_BUSY, O_CARRY, O_DIGIT_CARRY, O_ZERO, O_GLOBAL_INTERRUPT_ENABLE, O_POWER_DOWN_FLAG;
  logic O_PC_LOAD, O_FILE_WE, O_CORE_CLOCK_STOP, O_OSC_STOP, O_STACK_OVERFLOW;
  int miscompares = 0, tests_run = 0;
  rrsx_exec dut (.*);
  // 100 MHz clock
  always #5 I_CLOCK = ~I_CLOCK;
  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one instruction, results read just after the taking edge
  task automatic op(input logic [3:0] o, input logic [7:0] l, f, input logic d);
    @(posedge I_CLOCK);
    I_OP <= o;
    I_LITERAL <= l;
    I_CALL_ADDR <= {4'h5, l};
    I_FILE_DATA <= f;
    I_DEST <= d;
    I_OP_VALID <= 1'b1;
    @(posedge I_CLOCK);
    I_OP_VALID <= 1'b0;
    #1;
  endtask
  task automatic alu(input logic [3:0] o, input logic [7:0] l, f, input logic d,
                     input logic [7:0] r, input logic c, dc, z);
    op(o, l, f, d);
    chk({O_FILE_WE, d ? O_FILE_WDATA : O_W}, {d, r});
    chk({O_CARRY, O_DIGIT_CARRY, O_ZERO}, {c, dc, z});
  endtask
  // ==========================================
  // scenarios
  task automatic arith;
    alu(`RRSX_OP_LITERAL_XOR, 8'hAC, 8'h00, 0, 8'hAC, 0, 0, 0);
    alu(`RRSX_OP_LITERAL_XOR, 8'h5F, 8'h00, 0, 8'hF3, 0, 0, 0);
    alu(`RRSX_OP_FILE_XOR, 8'h00, 8'hF3, 0, 8'h00, 0, 0, 1);
    alu(`RRSX_OP_LITERAL_SUBTRACT, 8'h02, 8'h00, 0, 8'h02, 1, 1, 0);
    alu(`RRSX_OP_FILE_SUBTRACT, 8'h00, 8'h01, 1, 8'hFF, 0, 0, 0);
    alu(`RRSX_OP_FILE_SUBTRACT_BORROW, 8'h00, 8'h05, 0, 8'h02, 1, 1, 0);
    alu(`RRSX_OP_FILE_SUBTRACT_BORROW, 8'h00, 8'h02, 1, 8'h00, 1, 1, 1);
    alu(`RRSX_OP_ROTATE_LEFT, 8'h00, 8'hE6, 1, 8'hCD, 1, 1, 0);
    alu(`RRSX_OP_ROTATE_RIGHT, 8'h00, 8'h94, 0, 8'hCA, 0, 1, 0);
  endtask
  // fill all eight entries, unwind with every return kind
  task automatic stack_walk;
    logic [7:0] ew;
    logic eg;
    logic [3:0] c;
    ew = 8'hCA;
    eg = 1'b0;
    for (int i = 0; i < 8; i++) op(`RRSX_OP_CALL, 8'(i), 8'h00, 1'b0);
    chk(O_STACK_OVERFLOW, 1'b0);
    // a ninth push overflows; it reuses entry 0 with the same address
    op(`RRSX_OP_CALL, 8'h00, 8'h00, 1'b0);
    chk(O_STACK_OVERFLOW, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      c = 4'(i % 3 + 1);
      if (c == `RRSX_OP_LITERAL_RETURN) ew = 8'(i);
      eg = eg | (c == `RRSX_OP_INTERRUPT_RETURN);
      op(c, 8'(i), 8'h00, 1'b0);
      chk({O_BUSY, O_W}, {1'b1, ew});
      @(posedge I_CLOCK);
      #1;
      chk({O_PC_LOAD, O_BUSY, O_PC}, {2'b10, 4'h5, 8'(i)});
      chk({O_GLOBAL_INTERRUPT_ENABLE, O_CARRY, O_ZERO}, {eg, 2'b00});
    end
  endtask
  // halt wakes on the internal request, sleep only on the external one
  task automatic power_down(input logic [3:0] c, input logic s);
    op(c, 8'h00, 8'h00, 1'b0);
    chk({O_BUSY, O_CORE_CLOCK_STOP, O_OSC_STOP, O_POWER_DOWN_FLAG}, {2'b11, s, s});
    @(posedge I_CLOCK);
    I_INT_WAKE <= 1'b1;
    repeat (3) @(posedge I_CLOCK);
    I_INT_WAKE <= 1'b0;
    I_EXT_WAKE <= s;
    #1;
    chk(O_CORE_CLOCK_STOP, s);
    repeat (2) @(posedge I_CLOCK);
    I_EXT_WAKE <= 1'b0;
    #1;
    chk({O_CORE_CLOCK_STOP, O_OSC_STOP}, 0);
    op(`RRSX_OP_NONE, 8'h00, 8'h00, 1'b0);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    arith;
    stack_walk;
    power_down(`RRSX_OP_HALT, 1'b0);
    power_down(`RRSX_OP_SLEEP, 1'b1);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
